// ---- verilog/tcc_pkg.sv ----
// Overview of operation
// - Low data read returns selected channel low byte.
// - Low write loads shadow high plus low.
// - Unselected channels are not accessible.
// - Four flags, hardware sets, software clears.
// - Interrupt needs flag, channel and global enable.
// - Mode select zero means capture mode.
// - Capture copies timer count, sets flag.
// - Clear-on-event bit zeroes the timer.
// - Event select field picks capture source.
// - Pin events are edge only, selectable.
// - Pins sampled every system clock.
// - New capture overwrites data, no overrun check.
// - Internal triggers: timer overflows, comparators.
// - Any comparator interrupt event may trigger.
// - Channels A-D use port bits 0-3.
// - Converter output blocks pin capture C, D.
// - External memory mode blocks all pin capture.
// - Two-bit index selects channel A to D.
// - High writes go to one shared shadow.
// - Software cannot write capture-mode data.
// - Timer stopped: flags set, no data stored.
package tcc_pkg;
	localparam int NUM_CH = 4;
	// Byte addresses on the Wishbone bus (consecutive bytes, not word aligned).
	localparam logic [7:0] ADDR_INDEX = 8'hD1;
	localparam logic [7:0] ADDR_DATA_HIGH = 8'hD2;
	localparam logic [7:0] ADDR_DATA_LOW = 8'hD3;
	localparam logic [7:0] ADDR_CONTROL = 8'hD4;
	localparam logic [7:0] ADDR_FLAGS = 8'hD5;
	localparam logic [7:0] ADDR_GLOBAL = 8'hD6;
	localparam int ADDR_W = 10;
	// Control byte field positions.
	localparam int CTL_IEN = 7;
	localparam int CTL_CTC = 4;
	localparam int CTL_CCM = 3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// Event source encodings.
	typedef enum logic [2:0] {
		SRC_OFF = 3'b000,
		SRC_FALL = 3'b001,
		SRC_RISE = 3'b010,
		SRC_BOTH = 3'b011,
		SRC_T0OVF = 3'b100,
		SRC_T1OVF = 3'b101,
		SRC_CMPA = 3'b110,
		SRC_CMPB = 3'b111
	} tcc_src_e;
	// Internal trigger bundle.
	typedef struct packed {
		logic t0Ovf;
		logic t1Ovf;
		logic cmpA;
		logic cmpB;
	} tcc_trig_s;
endpackage : tcc_pkg

// ---- verilog/tcc_edge_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module tcc_edge_sync
	import tcc_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic nrst,
	// Pin and edges.
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// Two stages for metastability, third holds the previous sample.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// Edges from two consecutive synchronized samples.
	assign rise = s2_q & ~s3_q;
	assign fall = ~s2_q & s3_q;
endmodule : tcc_edge_sync
`default_nettype wire

// ---- verilog/tcc_capture_array.sv ----
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module tcc_capture_array
	import tcc_pkg::*;
#(
	parameter int CH = NUM_CH
)
(
	// System.
	input wire logic clock,
	input wire logic nrst,
	// Wishbone slave.
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [ADDR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	output logic wbAck,
	// Port 2 pins, bits 0 to 3.
	input wire logic [3:0] capturePins,
	input wire logic converterOnPins,
	input wire logic extMemOnPort,
	// Internal triggers and timer.
	input wire tcc_trig_s trig,
	input wire logic timerRunBit,
	input wire logic [15:0] timerCount,
	// Timer clear and interrupt request outputs.
	output logic timerClear,
	output logic irqRequest
);
	logic [1:0] channelIndex_q;
	logic [7:0] dataHighShadow_q;
	logic [7:0] ctl_q [CH];
	logic [15:0] channelDataWord_q [CH];
	logic [CH-1:0] flags_q;
	logic globalIen_q;
	logic [CH-1:0] rise;
	logic [CH-1:0] fall;
	logic [CH-1:0] capEvt;
	logic [CH-1:0] pinAllowed;
	logic [CH-1:0] ienVec;
	logic [CH-1:0] ctcVec;
	logic [CH-1:0] capStore;

	// Bus decode.
	wire busReq = wbCyc & wbStb & ~wbAck;
	wire wrLane = wbWe & wbSel[0];
	wire [7:0] adr = wbAdr[7:0];
	wire wrIndex = busReq & wrLane & (adr == ADDR_INDEX);
	wire wrHigh = busReq & wrLane & (adr == ADDR_DATA_HIGH);
	wire wrLow = busReq & wrLane & (adr == ADDR_DATA_LOW);
	wire wrCtl = busReq & wrLane & (adr == ADDR_CONTROL);
	wire wrFlags = busReq & wrLane & (adr == ADDR_FLAGS);
	wire wrGlobal = busReq & wrLane & (adr == ADDR_GLOBAL);
	wire [1:0] sel = channelIndex_q;
	wire [15:0] selWord = channelDataWord_q[sel];
	wire [7:0] selCtl = ctl_q[sel];

	// Read mux; unmapped addresses read zero.
	logic [7:0] rdByte;
	always_comb begin
		unique case (adr)
			ADDR_INDEX: rdByte = {6'h00, channelIndex_q};
			ADDR_DATA_HIGH: rdByte = selWord[15:8];
			ADDR_DATA_LOW: rdByte = selWord[7:0];
			ADDR_CONTROL: rdByte = selCtl;
			ADDR_FLAGS: rdByte = {4'h0, flags_q};
			ADDR_GLOBAL: rdByte = {7'h00, globalIen_q};
			default: rdByte = 8'h00;
		endcase
	end

	// Single-wait answer: ack one cycle after the strobe, then drop.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wbAck <= 1'b0;
			wbDatO <= 32'h0000_0000;
		end else begin
			wbAck <= busReq;
			wbDatO <= {24'h000000, rdByte};
		end
	end

	// Index, shadow and global enable registers.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			channelIndex_q <= 2'b00;
			dataHighShadow_q <= RST_BYTE;
			globalIen_q <= 1'b0;
		end else begin
			if (wrIndex) channelIndex_q <= wbDatI[1:0];
			if (wrHigh) dataHighShadow_q <= wbDatI[7:0];
			if (wrGlobal) globalIen_q <= wbDatI[0];
		end
	end

	// Per-channel edge detection, source selection and storage.
	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : gCh
			tcc_src_e src;
			logic pinEvt;
			logic intEvt;
			tcc_edge_sync uSync (
				.clock(clock),
				.nrst(nrst),
				.pin(capturePins[g]),
				.rise(rise[g]),
				.fall(fall[g])
			);
			assign src = tcc_src_e'(ctl_q[g][2:0]);
			// Pin capture lost to converter on C/D or external memory on all.
			assign pinAllowed[g] = ~extMemOnPort & ~(converterOnPins & (g >= 2));
			// Edge-only qualification; no level mode exists.
			assign pinEvt = pinAllowed[g] & (((src == SRC_FALL) & fall[g]) | ((src == SRC_RISE) & rise[g])
				| ((src == SRC_BOTH) & (rise[g] | fall[g])));
			// Any comparator interrupt event arrives on cmpA/cmpB.
			assign intEvt = ((src == SRC_T0OVF) & trig.t0Ovf) | ((src == SRC_T1OVF) & trig.t1Ovf)
				| ((src == SRC_CMPA) & trig.cmpA) | ((src == SRC_CMPB) & trig.cmpB);
			assign capEvt[g] = ~ctl_q[g][CTL_CCM] & (pinEvt | intEvt);
			// Data stored only while the timer runs.
			assign capStore[g] = capEvt[g] & timerRunBit;
			assign ienVec[g] = ctl_q[g][CTL_IEN];
			assign ctcVec[g] = ctl_q[g][CTL_CTC] & capStore[g];
			wire selHere = sel == 2'(g);
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					ctl_q[g] <= RST_BYTE;
					channelDataWord_q[g] <= RST_WORD;
				end else begin
					if (wrCtl && selHere) ctl_q[g] <= wbDatI[7:0];
					if (capStore[g]) channelDataWord_q[g] <= timerCount;
					else if (wrLow && selHere && ctl_q[g][CTL_CCM])
						channelDataWord_q[g] <= {dataHighShadow_q, wbDatI[7:0]};
				end
			end
		end
	endgenerate

	// Flags: write one to clear, hardware set wins.
	wire [CH-1:0] flagClr = wrFlags ? wbDatI[CH-1:0] : '0;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flags_q <= '0;
			timerClear <= 1'b0;
			irqRequest <= 1'b0;
		end else begin
			flags_q <= (flags_q & ~flagClr) | capEvt;
			timerClear <= |ctcVec;
			irqRequest <= globalIen_q & |(((flags_q & ~flagClr) | capEvt) & ienVec);
		end
	end

	// Checks.
	a_flag_set_wins: assert property (@(posedge clock) disable iff (!nrst)
		capEvt[0] |=> flags_q[0]) else $error("flag A lost on event");
	a_capture_data_stored: assert property (@(posedge clock) disable iff (!nrst)
		capStore[1] |=> channelDataWord_q[1] == $past(timerCount)) else $error("capture B wrong");
	a_stopped_no_store: assert property (@(posedge clock) disable iff (!nrst)
		(!timerRunBit && !(wrLow && sel == 2'd2)) |=> $stable(channelDataWord_q[2])) else $error("stored while stopped");
	a_capture_no_write: assert property (@(posedge clock) disable iff (!nrst)
		(wrLow && sel == 2'd2 && !ctl_q[2][CTL_CCM] && !capStore[2]) |=> $stable(channelDataWord_q[2]))
		else $error("write hit capture channel");
	a_irq_gating: assert property (@(posedge clock) disable iff (!nrst)
		!globalIen_q |=> !irqRequest) else $error("irq without global enable");
	a_extmem_block: assert property (@(posedge clock) disable iff (!nrst)
		extMemOnPort |-> !(capEvt[0] && ctl_q[0][2:0] inside {3'b001, 3'b010, 3'b011}))
		else $error("pin capture under ext memory");
	a_conv_block: assert property (@(posedge clock) disable iff (!nrst)
		converterOnPins |-> !(capEvt[3] && ctl_q[3][2:0] inside {3'b001, 3'b010, 3'b011}))
		else $error("pin capture under converter");
	a_ack_one_cycle: assert property (@(posedge clock) disable iff (!nrst)
		wbAck |=> !wbAck) else $error("ack held");
	a_low_read: assert property (@(posedge clock) disable iff (!nrst)
		(busReq && !wbWe && adr == ADDR_DATA_LOW) |=> wbDatO[7:0] == $past(selWord[7:0])) else $error("low read");
endmodule : tcc_capture_array
`default_nettype wire

// ---- tb/tcc_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far side of the array: the port pins and the internal trigger sources.
module tcc_src_model
	import tcc_pkg::*;
(
	// System.
	input wire logic clock,
	input wire logic nrst,
	// Requests from the bench.
	input wire logic [3:0] pinWant,
	input wire logic [3:0] fire,
	// Drive into the array.
	output logic [3:0] capturePins,
	output var tcc_trig_s trig
);
	int held;
	// A pin level changes only after standing three cycles, so the array never misses it.
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			capturePins <= 4'h0;
			held <= 0;
			trig <= '0;
		end else begin
			trig <= tcc_trig_s'(fire); // Comparator pulses come on the system clock, not the timer.
			held <= held + 1;
			if (pinWant != capturePins && held >= 2) begin
				capturePins <= pinWant;
				held <= 0;
			end
		end
	end
endmodule : tcc_src_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
	import tcc_pkg::*;
	logic clock = 0, nrst = 1, cyc = 0, stb = 0, we = 0, conv = 0, ext = 0, run = 1;
	logic ack, clr, irq;
	logic [9:0] adr = 10'h000;
	logic [31:0] datI = 32'h0, datO;
	logic [3:0] pinWant = 4'h0, fire = 4'h0, pins;
	logic [15:0] cnt = 16'h0000;
	logic [7:0] r, mctl[4];
	tcc_trig_s trig;
	int mismatches = 0, check_count = 0, clrSeen = 0, i, k, mflag = 0, mdata[4] = '{0, 0, 0, 0};
	tcc_src_model src (.clock(clock), .nrst(nrst), .pinWant(pinWant), .fire(fire), .capturePins(pins), .trig(trig));
	tcc_capture_array uut (.clock(clock), .nrst(nrst), .wbCyc(cyc), .wbStb(stb), .wbWe(we), .wbAdr(adr),
		.wbSel(4'hF), .wbDatI(datI), .wbDatO(datO), .wbAck(ack), .capturePins(pins), .converterOnPins(conv),
		.extMemOnPort(ext), .trig(trig), .timerRunBit(run), .timerCount(cnt), .timerClear(clr), .irqRequest(irq));
	// Clock and a count of timer clear pulses.
	always #20 clock = ~clock;
	always @(posedge clock) if (clr === 1'b1) clrSeen++;
	// Classic cycle: the request stands until ack is sampled high at an edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		{cyc, stb, we} <= {2'b11, w};
		adr <= {2'b00, a};
		datI <= {24'h0, d};
		@(posedge clock);
		while (ack !== 1'b1 && n++ < 20) @(posedge clock);
		// A slave that never answers counts against the run.
		if (ack !== 1'b1) mismatches++;
		r = datO[7:0];
		{cyc, stb, we} <= 3'b000;
	endtask : bus
	task automatic rd(input logic [7:0] a, input int e);
		bus(1'b0, a, 8'h00);
		`CHK(r, e[7:0])
	endtask : rd
	task automatic ctl(input int c, input logic [7:0] v);
		bus(1'b1, ADDR_INDEX, c[7:0]);
		bus(1'b1, ADDR_CONTROL, v);
		mctl[c] = v;
	endtask : ctl
	// Reference capture: flag always, data only while the timer runs.
	task automatic cap(input int c);
		mflag |= 1 << c;
		if (run) mdata[c] = cnt;
	endtask : cap
	task automatic all_chk();
		for (int j = 0; j < 4; j++) begin
			bus(1'b1, ADDR_INDEX, j[7:0]);
			rd(ADDR_DATA_LOW, mdata[j] & 255);
		end
		rd(ADDR_FLAGS, mflag);
	endtask : all_chk
	task automatic close_out();
		if (mismatches == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	// Watchdog against a hung handshake.
	initial begin
		repeat (6000) @(posedge clock);
		mismatches++;
		close_out();
	end
	// Main sequence.
	initial begin
		void'($urandom(80));
		nrst <= 1'b0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		rd(ADDR_FLAGS, 0);
		rd(8'hE0, 0);
		// Compare-mode writes take the shared shadow; a capture-mode write is dropped.
		ctl(0, 8'h08);
		bus(1'b1, ADDR_DATA_HIGH, 8'hAB);
		bus(1'b1, ADDR_DATA_LOW, 8'hCD);
		ctl(1, 8'h08);
		bus(1'b1, ADDR_DATA_LOW, 8'h12);
		ctl(2, 8'h00);
		bus(1'b1, ADDR_DATA_LOW, 8'h55);
		mdata[0] = 'hABCD;
		mdata[1] = 'hAB12;
		all_chk();
		// Each internal trigger on its own channel, with interrupts on.
		bus(1'b1, ADDR_GLOBAL, 8'h01);
		for (i = 0; i < 4; i++) ctl(i, 8'h84 + i[7:0]);
		for (i = 0; i < 4; i++) begin
			cnt <= 16'($urandom);
			fire <= 4'h8 >> i;
			@(posedge clock);
			fire <= 4'h0;
			cap(i);
			repeat (3) @(posedge clock);
			`CHK(irq, 1'b1)
			all_chk();
		end
		bus(1'b1, ADDR_GLOBAL, 8'h00);
		repeat (2) @(posedge clock);
		`CHK(irq, 1'b0)
		bus(1'b1, ADDR_FLAGS, 8'h0F);
		mflag = 0;
		all_chk();
		// Capture that also clears the timer.
		ctl(0, 8'h14);
		cnt <= 16'($urandom);
		fire <= 4'h8;
		@(posedge clock);
		fire <= 4'h0;
		cap(0);
		all_chk();
		// Pin edges under the blocking modes and a stopped timer.
		for (i = 0; i < 4; i++) ctl(i, 8'h80 | (i == 0 ? 8'h02 : i == 1 ? 8'h01 : 8'h03));
		for (k = 0; k < 5; k++) begin
			conv <= (k == 1);
			ext <= (k == 2);
			run <= (k != 3);
			cnt <= 16'($urandom);
			pinWant <= k[0] ? 4'h0 : 4'hF;
			repeat (8) @(posedge clock);
			for (i = 0; i < 4; i++)
				if (!(ext || (conv && i >= 2)) && (mctl[i][1:0] == 3 || mctl[i][1:0] == (k[0] ? 1 : 2))) cap(i);
			all_chk();
		end
		`CHK(clrSeen, 1)
		close_out();
	end
endmodule : tb_top
`default_nettype wire
